// [core/dcfmp_pkg.sv]
package dcfmp_pkg;
  // word and storage geometry
  localparam int DATA_W = 36;
  localparam int ADDR_W = 6;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] FIFO_DEPTH = 7'h40;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  // two-entry buffer in the write path
  localparam int BUF_W = DATA_W;
  localparam int BUF_DEPTH = 2;
  // almost-flag offset choices
  localparam int OFS_W = 5;
  localparam logic [OFS_W-1:0] OFS_16 = 5'h10;
  localparam logic [OFS_W-1:0] OFS_12 = 5'h0C;
  localparam logic [OFS_W-1:0] OFS_8 = 5'h08;
  localparam logic [OFS_W-1:0] OFS_4 = 5'h04;
  localparam logic [OFS_W-1:0] OFS_RST = OFS_4;
  // values held while reset is applied
  localparam logic [1:0] FULL_SYNC_RST = 2'h0;
  localparam logic [1:0] AFULL_SYNC_RST = 2'h3;
  localparam logic [1:0] EMPTY_SYNC_RST = 2'h0;
  localparam logic [1:0] AEMPTY_SYNC_RST = 2'h0;
  localparam logic MAIL_FLAG_RST = 1'b1;
endpackage : dcfmp_pkg

// [core/dcfmp_skid_buf.sv]
`timescale 1ns/1ns
`default_nettype none
module dcfmp_skid_buf #(
  parameter int WIDTH = dcfmp_pkg::BUF_W,
  parameter int DEPTH = dcfmp_pkg::BUF_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // occupancy
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST = (PW)'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] data;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } dcfmp_buf_t;

  dcfmp_buf_t s_r;
  dcfmp_buf_t s_nxt;
  logic push;
  logic pop;

  assign in_ready_o = (s_r.cnt != FULL_CNT);
  assign out_valid_o = (s_r.cnt != '0);
  assign out_data_o = s_r.data[s_r.rp];
  assign count_o = s_r.cnt;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.data[s_r.wp] = in_data_i;
      s_nxt.wp = (s_r.wp == LAST) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == LAST) ? '0 : s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : dcfmp_skid_buf
`default_nettype wire

// [core/dcfmp_parity.sv]
`timescale 1ns/1ns
`default_nettype none
module dcfmp_parity (
  // outgoing word and generation control
  input wire logic [dcfmp_pkg::DATA_W-1:0] data_i,
  input wire logic gen_i,
  input wire logic odd_i,
  // resolved bus level for checking
  input wire logic [dcfmp_pkg::DATA_W-1:0] check_i,
  // results
  output logic [dcfmp_pkg::DATA_W-1:0] data_o,
  output logic err_n_o
);
  localparam int LW = dcfmp_pkg::LANE_W;
  logic [dcfmp_pkg::LANES-1:0] lane_ok;

  // top bit of each 9-bit lane carries its parity
  for (genvar i = 0; i < dcfmp_pkg::LANES; i++) begin : g_lane
    logic [LW-2:0] low;
    assign low = data_i[i*LW +: LW-1];
    assign data_o[i*LW +: LW-1] = low;
    assign data_o[i*LW+LW-1] = gen_i ? (^low ^ odd_i) : data_i[i*LW+LW-1];
    assign lane_ok[i] = ((^check_i[i*LW +: LW]) == odd_i);
  end

  assign err_n_o = &lane_ok;
endmodule : dcfmp_parity
`default_nettype wire

// [core/dcfmp_top.sv]
// Operation
// - Reset may be applied and released at any time.
// - Reset clears pointers; full, empty, almost-empty low; almost-full high.
// - Reset drives both mailbox flags high.
// - Full flag rises on the second edge after reset release.
// - Offset select pins load 16, 12, 8 or 4 at reset release.
// - Port A bus drives only while its select and direction are low.
// - Port A write cycle with full flag high stores the word.
// - Port B bus drives only while its select and direction are low.
// - Port B read cycle with empty flag high loads the output register; the code also needs the live word count nonzero.
// - Transfer gate low means no transfer on that port.
// - Mail 1 write clears its flag; port B shows new mail at once.
// - Mail 2 write clears its flag; port A shows new mail at once.
// - Port A mail read sets the mail 2 flag high.
// - Parity error flags follow bus and polarity combinationally; no port control enters them.
// - Parity generation replaces lane top bits only during mailbox reads.
// - Full flags pass two stages; empty flags pass two stages.
// - Almost-empty low at X words or fewer; almost-full low at 64-X up.
// - Port B mail read sets the mail 1 flag high.
`timescale 1ns/1ns
`default_nettype none
module dcfmp_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration
  input wire logic offset_sel0_i,
  input wire logic offset_sel1_i,
  input wire logic odd_even_i,
  // port A controls
  input wire logic port_a_chip_sel_n_i,
  input wire logic port_a_dir_sel_i,
  input wire logic port_a_xfer_gate_i,
  input wire logic port_a_mail_sel_i,
  input wire logic port_a_parity_gen_i,
  // port A bus
  input wire logic [dcfmp_pkg::DATA_W-1:0] port_a_bus_i,
  output logic [dcfmp_pkg::DATA_W-1:0] port_a_bus_o,
  output logic port_a_bus_oe_n_o,
  output logic port_a_parity_err_n_o,
  // port B controls
  input wire logic port_b_chip_sel_n_i,
  input wire logic port_b_dir_sel_i,
  input wire logic port_b_xfer_gate_i,
  input wire logic port_b_mail_sel_i,
  input wire logic port_b_parity_gen_i,
  // port B bus
  input wire logic [dcfmp_pkg::DATA_W-1:0] port_b_bus_i,
  output logic [dcfmp_pkg::DATA_W-1:0] port_b_bus_o,
  output logic port_b_bus_oe_n_o,
  output logic port_b_parity_err_n_o,
  // flags
  output logic full_flag_n_o,
  output logic almost_full_flag_n_o,
  output logic empty_flag_n_o,
  output logic almost_empty_flag_n_o,
  output logic mail1_full_n_o,
  output logic mail2_full_n_o
);
  localparam int DW = dcfmp_pkg::DATA_W;
  localparam int AW = dcfmp_pkg::ADDR_W;
  localparam int CW = dcfmp_pkg::CNT_W;
  localparam int OW = dcfmp_pkg::OFS_W;
  localparam int BCW = $clog2(dcfmp_pkg::BUF_DEPTH) + 1;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [DW-1:0] out_word;
    logic [DW-1:0] mail1;
    logic [DW-1:0] mail2;
    logic mail1_full_n_n;
    logic mail2_full_n_n;
    logic [OW-1:0] ofs;
    logic rst_seen;
    logic [1:0] ff_s;
    logic [1:0] af_s;
    logic [1:0] ef_s;
    logic [1:0] ae_s;
  } dcfmp_state_t;

  dcfmp_state_t s_r;
  dcfmp_state_t s_nxt;
  logic [DW-1:0] mem_r [0:(1<<AW)-1];

  logic a_act;
  logic b_act;
  logic wr_req;
  logic wr_acc;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [DW-1:0] buf_out_data;
  logic [BCW-1:0] buf_cnt;
  logic push;
  logic rd_go;
  logic mail1_wr;
  logic mail1_rd;
  logic mail2_wr;
  logic mail2_rd;
  logic [CW:0] total;
  logic raw_full_n;
  logic raw_afull_n;
  logic raw_empty_n;
  logic raw_aempty_n;
  logic [DW-1:0] a_word;
  logic [DW-1:0] b_word;
  logic a_gen;
  logic b_gen;

  ////////////////////////////////////////////////////////////////////////
  // port decoding: nothing happens on an edge with the gate low
  assign a_act = !port_a_chip_sel_n_i && port_a_xfer_gate_i;
  assign b_act = !port_b_chip_sel_n_i && port_b_xfer_gate_i;
  assign wr_req = a_act && port_a_dir_sel_i && !port_a_mail_sel_i
                  && full_flag_n_o;
  assign wr_acc = wr_req && buf_in_ready;
  // dir low on port A without mail select decodes to nothing
  assign mail2_rd = a_act && !port_a_dir_sel_i && port_a_mail_sel_i;
  assign mail1_wr = a_act && port_a_dir_sel_i && port_a_mail_sel_i;
  assign mail2_wr = b_act && port_b_dir_sel_i && port_b_mail_sel_i;
  assign mail1_rd = b_act && !port_b_dir_sel_i && port_b_mail_sel_i;
  // both the lagging flag and the live count must agree before a read
  assign rd_go = b_act && !port_b_dir_sel_i && !port_b_mail_sel_i
                 && empty_flag_n_o && (s_r.cnt != '0);

  ////////////////////////////////////////////////////////////////////////
  // write path buffer soaks up writes taken while the full flag lags
  assign push = buf_out_valid && (s_r.cnt != dcfmp_pkg::FIFO_DEPTH);
  assign buf_out_ready = push;

  dcfmp_skid_buf u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(wr_req),
    .in_ready_o(buf_in_ready),
    .in_data_i(port_a_bus_i),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_out_ready),
    .out_data_o(buf_out_data),
    .count_o(buf_cnt)
  );

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[s_r.wr_ptr] <= buf_out_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // raw level compares ahead of the two-stage flag chains
  assign total = {1'b0, s_r.cnt} + (CW+1)'(buf_cnt);
  assign raw_full_n = (total < {1'b0, dcfmp_pkg::FIFO_DEPTH});
  assign raw_empty_n = (s_r.cnt != '0);
  assign raw_aempty_n = (s_r.cnt > CW'(s_r.ofs));
  assign raw_afull_n = (total < ((CW+1)'(dcfmp_pkg::FIFO_DEPTH)
                                 - (CW+1)'(s_r.ofs)));

  always_comb begin
    s_nxt = s_r;
    // offset is caught on the first edge after reset lets go
    if (s_r.rst_seen) begin
      s_nxt.rst_seen = 1'b0;
      case ({offset_sel1_i, offset_sel0_i})
        2'b11: s_nxt.ofs = dcfmp_pkg::OFS_16;
        2'b10: s_nxt.ofs = dcfmp_pkg::OFS_12;
        2'b01: s_nxt.ofs = dcfmp_pkg::OFS_8;
        default: s_nxt.ofs = dcfmp_pkg::OFS_4;
      endcase
    end
    if (push) begin
      s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
    end
    if (rd_go) begin
      s_nxt.out_word = mem_r[s_r.rd_ptr];
      s_nxt.rd_ptr = s_r.rd_ptr + 1'b1;
    end
    if (push && !rd_go) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (rd_go && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
    // arriving mail wins over a read in the same cycle
    if (mail1_rd) begin
      s_nxt.mail1_full_n_n = 1'b1;
    end
    if (mail1_wr) begin
      s_nxt.mail1 = port_a_bus_i;
      s_nxt.mail1_full_n_n = 1'b0;
    end
    if (mail2_rd) begin
      s_nxt.mail2_full_n_n = 1'b1;
    end
    if (mail2_wr) begin
      s_nxt.mail2 = port_b_bus_i;
      s_nxt.mail2_full_n_n = 1'b0;
    end
    s_nxt.ff_s = {s_r.ff_s[0], raw_full_n};
    s_nxt.af_s = {s_r.af_s[0], raw_afull_n};
    s_nxt.ef_s = {s_r.ef_s[0], raw_empty_n};
    s_nxt.ae_s = {s_r.ae_s[0], raw_aempty_n};
  end

  // synchronous reset: a release at any point takes effect next edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.ofs <= dcfmp_pkg::OFS_RST;
      s_r.rst_seen <= 1'b1;
      s_r.mail1_full_n_n <= dcfmp_pkg::MAIL_FLAG_RST;
      s_r.mail2_full_n_n <= dcfmp_pkg::MAIL_FLAG_RST;
      s_r.ff_s <= dcfmp_pkg::FULL_SYNC_RST;
      s_r.af_s <= dcfmp_pkg::AFULL_SYNC_RST;
      s_r.ef_s <= dcfmp_pkg::EMPTY_SYNC_RST;
      s_r.ae_s <= dcfmp_pkg::AEMPTY_SYNC_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign full_flag_n_o = s_r.ff_s[1];
  assign almost_full_flag_n_o = s_r.af_s[1];
  assign empty_flag_n_o = s_r.ef_s[1];
  assign almost_empty_flag_n_o = s_r.ae_s[1];
  assign mail1_full_n_o = s_r.mail1_full_n_n;
  assign mail2_full_n_o = s_r.mail2_full_n_n;

  ////////////////////////////////////////////////////////////////////////
  // bus drive and parity; mail select acts without a clock edge
  assign port_a_bus_oe_n_o = port_a_chip_sel_n_i | port_a_dir_sel_i;
  assign port_b_bus_oe_n_o = port_b_chip_sel_n_i | port_b_dir_sel_i;
  assign a_word = port_a_mail_sel_i ? s_r.mail2 : '0;
  assign b_word = port_b_mail_sel_i ? s_r.mail1 : s_r.out_word;
  assign a_gen = port_a_parity_gen_i && !port_a_bus_oe_n_o
                 && port_a_mail_sel_i;
  assign b_gen = port_b_parity_gen_i && !port_b_bus_oe_n_o
                 && port_b_mail_sel_i;

  // checks run on the resolved wire, so a driven word is checked too
  dcfmp_parity u_par_a (
    .data_i(a_word),
    .gen_i(a_gen),
    .odd_i(odd_even_i),
    .check_i(port_a_bus_i),
    .data_o(port_a_bus_o),
    .err_n_o(port_a_parity_err_n_o)
  );

  dcfmp_parity u_par_b (
    .data_i(b_word),
    .gen_i(b_gen),
    .odd_i(odd_even_i),
    .check_i(port_b_bus_i),
    .data_o(port_b_bus_o),
    .err_n_o(port_b_parity_err_n_o)
  );

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  reset_flags_a: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> !full_flag_n_o && !empty_flag_n_o && !almost_empty_flag_n_o
              && almost_full_flag_n_o)
    else $error("flags wrong after reset");
  mail_reset_a: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> mail1_full_n_o && mail2_full_n_o)
    else $error("mail flags not high after reset");
  full_rise_a: assert property (@(posedge clk_i) disable iff (1'b0)
    (!rst_i && $past(rst_i)) |-> !full_flag_n_o ##1 !rst_i && !full_flag_n_o
      ##1 (rst_i || full_flag_n_o))
    else $error("full flag not raised on second edge");
  offset_load_a: assert property ((!rst_i && $past(rst_i)) |=>
    s_r.ofs == ($past(offset_sel1_i) ?
      ($past(offset_sel0_i) ? dcfmp_pkg::OFS_16 : dcfmp_pkg::OFS_12) :
      ($past(offset_sel0_i) ? dcfmp_pkg::OFS_8 : dcfmp_pkg::OFS_4)))
    else $error("offset not loaded at release");
  fifo_write_a: assert property (wr_acc |=>
    total == $past(total) + 1'b1 - (CW+1)'($past(rd_go)))
    else $error("accepted write not counted");
  fifo_read_a: assert property (rd_go |=>
    s_r.rd_ptr == $past(s_r.rd_ptr) + 1'b1
      && s_r.out_word == $past(mem_r[s_r.rd_ptr]))
    else $error("read did not advance output register");
  mail1_clear_a: assert property (mail1_wr |=>
    !mail1_full_n_o && s_r.mail1 == $past(port_a_bus_i))
    else $error("mail 1 write not seen");
  mail2_read_a: assert property ((mail2_rd && !mail2_wr) |=>
    mail2_full_n_o)
    else $error("mail 2 read did not set flag");
  mail_bypass_a: assert property ((!port_b_bus_oe_n_o && port_b_mail_sel_i
    && !port_b_parity_gen_i) |-> port_b_bus_o == s_r.mail1)
    else $error("port B not showing mail 1");
  no_a_read_a: assert property ((a_act && !port_a_dir_sel_i && !rd_go
    && !push) |=> s_r.rd_ptr == $past(s_r.rd_ptr))
    else $error("port A moved read pointer");
  ae_level_a: assert property ((!$past(rst_i) && !$past(rst_i, 2)) |->
    almost_empty_flag_n_o == ($past(s_r.cnt, 2) > CW'($past(s_r.ofs, 2))))
    else $error("almost-empty flag off level");
endmodule : dcfmp_top
`default_nettype wire

// [test/dcfmp_bus_model.sv]
`timescale 1ns/1ns
`default_nettype none
module dcfmp_bus_model (
  // clock
  input wire logic clk_i,
  // device side of the pin
  input wire logic [dcfmp_pkg::DATA_W-1:0] dev_data_i,
  input wire logic dev_oe_n_i,
  // host side of the pin
  input wire logic [dcfmp_pkg::DATA_W-1:0] host_data_i,
  input wire logic host_en_i,
  // resolved wire level
  output logic [dcfmp_pkg::DATA_W-1:0] bus_o
);
  logic [dcfmp_pkg::DATA_W-1:0] last_r;
  always_ff @(posedge clk_i) begin
    last_r <= bus_o;
  end
  // undriven wire inverts so a stale value can never pass as valid
  always_comb begin
    if (!dev_oe_n_i) begin
      bus_o = dev_data_i;
    end else if (host_en_i) begin
      bus_o = host_data_i;
    end else begin
      bus_o = ~last_r;
    end
  end
endmodule : dcfmp_bus_model
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int W = dcfmp_pkg::DATA_W;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic fs0 = 1'b0, fs1 = 1'b0, odd = 1'b0;
  logic a_cs = 1'b1, a_dir = 1'b0, a_gate = 1'b0, a_mail = 1'b0;
  logic b_cs = 1'b1, b_dir = 1'b0, b_gate = 1'b0, b_mail = 1'b0;
  logic a_pg = 1'b0, b_pg = 1'b0;
  logic [W-1:0] a_hd = '0, b_hd = '0, d, last;
  wire logic [W-1:0] a_bus, b_bus, a_do, b_do;
  wire logic a_oe, b_oe, a_pe, b_pe, ff, af, ef, ae, m1, m2;
  int n_mismatch = 0, comparisons = 0, cycles = 0, cnt, x;
  logic [W-1:0] q[$];

  dcfmp_top i_dcfmp_top (.clk_i(clk_i), .rst_i(rst_i),
    .offset_sel0_i(fs0), .offset_sel1_i(fs1), .odd_even_i(odd),
    .port_a_chip_sel_n_i(a_cs), .port_a_dir_sel_i(a_dir),
    .port_a_xfer_gate_i(a_gate), .port_a_mail_sel_i(a_mail),
    .port_a_parity_gen_i(a_pg), .port_a_bus_i(a_bus), .port_a_bus_o(a_do),
    .port_a_bus_oe_n_o(a_oe), .port_a_parity_err_n_o(a_pe),
    .port_b_chip_sel_n_i(b_cs), .port_b_dir_sel_i(b_dir),
    .port_b_xfer_gate_i(b_gate), .port_b_mail_sel_i(b_mail),
    .port_b_parity_gen_i(b_pg), .port_b_bus_i(b_bus), .port_b_bus_o(b_do),
    .port_b_bus_oe_n_o(b_oe), .port_b_parity_err_n_o(b_pe),
    .full_flag_n_o(ff), .almost_full_flag_n_o(af), .empty_flag_n_o(ef),
    .almost_empty_flag_n_o(ae), .mail1_full_n_o(m1), .mail2_full_n_o(m2));
  dcfmp_bus_model i_model_a (.clk_i(clk_i), .dev_data_i(a_do),
    .dev_oe_n_i(a_oe), .host_data_i(a_hd), .host_en_i(a_dir), .bus_o(a_bus));
  dcfmp_bus_model i_model_b (.clk_i(clk_i), .dev_data_i(b_do),
    .dev_oe_n_i(b_oe), .host_data_i(b_hd), .host_en_i(b_dir), .bus_o(b_bus));

  initial begin
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [W-1:0] rnd();
    return W'({$urandom(), $urandom()});
  endfunction : rnd
  function automatic logic [W-1:0] gen_par(input logic [W-1:0] w, input logic o);
    for (int i = 0; i < dcfmp_pkg::LANES; i++) begin
      w[9*i+8] = (^w[9*i +: 8]) ^ o;
    end
    return w;
  endfunction : gen_par
  function automatic logic par_ok(input logic [W-1:0] w, input logic o);
    par_ok = 1'b1;
    for (int i = 0; i < dcfmp_pkg::LANES; i++) begin
      if ((^w[9*i +: dcfmp_pkg::LANE_W]) != o) par_ok = 1'b0;
    end
  endfunction : par_ok
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [W-1:0] e, input logic [W-1:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  ////////////////////////////////////////////////////////////////////////
  // each call starts after an edge and returns on the edge it used
  task automatic port_a(input logic cs, dr, g, m, input logic [W-1:0] v);
    #1;
    a_cs = cs;
    a_dir = dr;
    a_gate = g;
    a_mail = m;
    a_hd = v;
    @(posedge clk_i);
  endtask : port_a
  task automatic port_b(input logic cs, dr, g, m, input logic [W-1:0] v);
    #1;
    b_cs = cs;
    b_dir = dr;
    b_gate = g;
    b_mail = m;
    b_hd = v;
    @(posedge clk_i);
  endtask : port_b
  task automatic quiet(input int n);
    #1;
    a_gate = 1'b0;
    b_gate = 1'b0;
    repeat (n) @(posedge clk_i);
    #2;
  endtask : quiet
  task automatic do_reset(input logic s1, s0, input int n);
    #1;
    rst_i = 1'b1;
    fs1 = s1;
    fs0 = s0;
    repeat (n) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    chk("reset flags", W'({ff, ef, ae, af, m1, m2}), W'(6'h07));
    @(posedge clk_i);
    #2;
    chk("full early", W'(ff), W'(1'b0));
    @(posedge clk_i);
    #2;
    chk("full late", W'(ff), W'(1'b1));
  endtask : do_reset
  task automatic chk_flags();
    cnt = q.size();
    chk("flags", W'({cnt != 0, cnt > x, cnt < 64 - x, cnt < 64}),
      W'({ef, ae, af, ff}));
  endtask : chk_flags
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    void'($urandom(32'h22d6));
    do_reset(1'b0, 1'b0, 3);
    for (int i = 0; i < 4; i++) begin
      #1;
      {a_cs, a_dir} = 2'(i);
      {b_cs, b_dir} = 2'(i);
      #1;
      chk("drive enables", W'({a_oe, b_oe}), W'({2{i != 0}}));
    end
    for (int i = 0; i < 16; i++) begin
      #1;
      {a_cs, a_dir, b_cs, b_dir, odd} = 5'b01011 ^ 5'(i[0]);
      a_hd = i[1] ? gen_par(rnd(), odd) : rnd();
      b_hd = rnd();
      #1;
      chk("parity a", W'(a_pe), W'(par_ok(a_hd, odd)));
      chk("parity b", W'(b_pe), W'(par_ok(b_hd, odd)));
    end
    for (int c = 0; c < 4; c++) begin
      x = (c == 0) ? 4 : (c == 1) ? 8 : (c == 2) ? 12 : 16;
      do_reset(c[1], c[0], 4);
      q.delete();
      for (int n = 1; n <= 65; n++) begin
        d = rnd();
        port_a(1'b0, 1'b1, 1'b1, 1'b0, d);
        if (n <= 64) q.push_back(d);
        quiet(3);
        chk_flags();
      end
      port_a(1'b0, 1'b0, 1'b1, 1'b0, rnd());
      port_a(1'($urandom()), 1'($urandom()), 1'b0, 1'b0, rnd());
      port_b(1'($urandom()), 1'($urandom()), 1'b0, 1'b0, rnd());
      b_pg = 1'b1;
      for (int n = 0; n < 64; n++) begin
        port_b(1'b0, 1'b0, 1'b1, 1'b0, '0);
        last = q.pop_front();
        #1;
        chk("fifo word", last, b_do);
        quiet(3);
        chk_flags();
      end
      port_b(1'b0, 1'b0, 1'b1, 1'b0, '0);
      quiet(2);
      chk("empty read", last, b_do);
    end
    // mail 1 from port A with port B already looking at it
    odd = 1'($urandom());
    b_pg = 1'b0;
    b_mail = 1'b1;
    d = rnd();
    port_a(1'b0, 1'b1, 1'b1, 1'b1, d);
    // gate off before the read, or the write repeats and beats it
    quiet(0);
    chk("mail1 flag", W'(m1), W'(1'b0));
    chk("mail1 view", d, b_bus);
    b_mail = 1'b0;
    #1;
    chk("fifo view", last, b_do);
    b_mail = 1'b1;
    b_pg = 1'b1;
    #1;
    chk("mail1 parity", gen_par(d, odd), b_do);
    chk("gen parity ok", W'(b_pe), W'(1'b1));
    port_b(1'b0, 1'b0, 1'b1, 1'b1, '0);
    quiet(0);
    chk("mail1 read", W'(m1), W'(1'b1));
    // mail 2 from port B with port A already looking at it
    a_cs = 1'b0;
    a_dir = 1'b0;
    a_mail = 1'b1;
    d = rnd();
    port_b(1'b0, 1'b1, 1'b1, 1'b1, d);
    quiet(0);
    chk("mail2 flag", W'(m2), W'(1'b0));
    chk("mail2 view", d, a_bus);
    a_pg = 1'b1;
    #1;
    chk("mail2 parity", gen_par(d, odd), a_do);
    port_a(1'b0, 1'b0, 1'b1, 1'b1, '0);
    quiet(0);
    chk("mail2 read", W'(m2), W'(1'b1));
    summarize();
  end
endmodule : tb_top
`default_nettype wire
